// ===== hw/rtc_calendar_alarm_control.sv
// Summary of operation
// R1: Clock counts only while enabled; enable writable only while value writes unlocked.
// R2: Time window writes ignored while locked, accepted while unlocked.
// R3: Ripple status set near rollover; software trusts two matching reads.
// R4: Half-second phase reads 0 then 1; cleared by writing seconds/minutes low byte.
// R5: Pin driven only while output enable set.
// R6: Time pointer decrements on each high-byte access, stopping at zero.
// R7: Time pointer pairs: minutes/seconds, weekday/hours, month/day, reserved/year.
// R8: Configuration cleared only by power-on reset; no other reset stops the clock.
// R9: Signed calibration adds or subtracts four source pulses per unit each minute.
// R10: Output select: alarm pulse, seconds clock, source clock; code 3 reserved.
// R11: Alarm enable self-clears after event when repeat is zero and chime off.
// R12: Repeat counter decrements per event; holds at zero unless chime wraps it.
// R13: Alarm pointer wraps past zero with chime, stops at zero without.
// R14: Mask picks interval from half second to year; other codes reserved.
// R15: Yearly alarm on February 29 fires only in leap years.
// R16: Alarm pointer decrements on each high-byte access, stopping at zero unless chime wraps it.
// R17: Alarm pointer pairs: min/sec, weekday/hour, month/day; code 3 unimplemented.
// R18: Repeat of all ones gives 255 more alarms; zero gives none.
// R19: Calendar spans years 00 to 99 with leap years, 24-hour time.
// R20: Time advances per second and exposes the half-second phase.
// R21: Timebase derived from the 32.768 kHz source clock input.
// R22: All time and date fields are held in BCD.
// R23: Calendar value writes accepted only while unlocked.
// R24: Enabled alarm fires on unmasked field match and pulses the alarm output.
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_control #(
  parameter int HALF_TICKS = rtc_pkg::HALF_TICKS,
  parameter int SYNC_TICKS = rtc_pkg::SYNC_TICKS
) (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Power-on reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic osc_in, // 32.768 kHz source clock level
  output logic rtc_pin_o, // Output pin level
  output logic rtc_pin_oe_n // Output pin enable, active low
);
  localparam logic signed [17:0] SEC_END = 18'(2 * HALF_TICKS - 1);
  localparam logic signed [17:0] HALF_AT = 18'(HALF_TICKS);
  localparam logic signed [17:0] HALF_END = 18'(HALF_TICKS - 1);
  localparam logic signed [17:0] SYNC_AT = 18'(2 * HALF_TICKS - SYNC_TICKS);

  logic en_reg, unlock_reg, oe_reg, sync_reg, phase_reg;
  logic [1:0] tptr_reg, aptr_reg, sel_reg;
  logic [7:0] cal_reg, rpt_reg;
  logic aen_reg, chime_reg;
  logic [3:0] alarm_interval_mask_reg;
  rtc_pkg::time_s now_reg, now_next, alm_reg;
  logic signed [17:0] presc_reg;
  logic osc_d_reg, sec_d_reg, half_d_reg, apulse_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg, pin_reg, pin_oe_n_reg;
  logic setup, acc, wr, rd, src_tick, sec_tick, half_tick, hit, evt;
  logic sec_eq, min_eq, hour_eq, wday_eq, day_eq, mon_eq;
  logic [7:0] rbyte;
  logic mapped;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4])
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    case (m)
      rtc_pkg::FEB: last_day = is_leap(y) ? rtc_pkg::D29 : rtc_pkg::D28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = rtc_pkg::D30;
      default: last_day = rtc_pkg::D31;
    endcase
  endfunction

  assign setup = psel && !penable;
  assign acc = psel && penable && pready_reg;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  // Source clock arrives as a synchronous level; its rising edge is one tick
  assign src_tick = osc_in && !osc_d_reg && en_reg; // [R1] [R21]
  assign sec_tick = src_tick && (presc_reg == SEC_END); // [R20]
  assign half_tick = src_tick && (presc_reg == HALF_END);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      osc_d_reg <= 1'b0;
    else
      osc_d_reg <= osc_in;
  end

  // Calibration reloads the prescaler once a minute: a positive start shortens the minute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      presc_reg <= '0;
    else if (wr && paddr == rtc_pkg::OFS_TVL && unlock_reg && tptr_reg == rtc_pkg::PTR_0)
      presc_reg <= '0; // [R4]
    else if (sec_tick && now_reg.second == rtc_pkg::MAX_SEC)
      presc_reg <= {{8{cal_reg[7]}}, cal_reg, 2'b00}; // [R9]
    else if (sec_tick)
      presc_reg <= '0;
    else if (src_tick)
      presc_reg <= presc_reg + 18'sh1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      phase_reg <= presc_reg >= HALF_AT; // [R4] [R20]
      sync_reg <= en_reg && (presc_reg >= SYNC_AT); // [R3]
    end
  end

  // Calendar cascade, all fields BCD
  always_comb begin
    now_next = now_reg;
    if (sec_tick) begin
      now_next.second = bcd_inc(now_reg.second); // [R22]
      if (now_reg.second == rtc_pkg::MAX_SEC) begin
        now_next.second = '0;
        now_next.minute = bcd_inc(now_reg.minute);
        if (now_reg.minute == rtc_pkg::MAX_SEC) begin
          now_next.minute = '0;
          now_next.hour = bcd_inc(now_reg.hour);
          if (now_reg.hour == rtc_pkg::MAX_HOUR) begin // [R19]
            now_next.hour = '0;
            now_next.wday = (now_reg.wday == rtc_pkg::MAX_WDAY) ? '0 : now_reg.wday + 8'h1;
            now_next.day = bcd_inc(now_reg.day);
            if (now_reg.day == last_day(now_reg.month, now_reg.year)) begin // [R19]
              now_next.day = 8'h01;
              now_next.month = bcd_inc(now_reg.month);
              if (now_reg.month == rtc_pkg::MAX_MONTH) begin
                now_next.month = 8'h01;
                now_next.year = (now_reg.year == rtc_pkg::MAX_YEAR) ? '0 : bcd_inc(now_reg.year);
              end
            end
          end
        end
      end
    end
  end

  // Software writes win over a coinciding tick in the same field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      now_reg <= rtc_pkg::TIME_RST;
    else begin
      now_reg <= now_next;
      if (wr && unlock_reg && paddr == rtc_pkg::OFS_TVL) begin // [R2] [R23]
        case (tptr_reg) // [R7]
          rtc_pkg::PTR_0: now_reg.second <= pwdata[7:0] & rtc_pkg::M_SEC;
          rtc_pkg::PTR_1: now_reg.hour <= pwdata[7:0] & rtc_pkg::M_HOUR;
          rtc_pkg::PTR_2: now_reg.day <= pwdata[7:0] & rtc_pkg::M_HOUR;
          default: now_reg.year <= pwdata[7:0];
        endcase
      end
      if (wr && unlock_reg && paddr == rtc_pkg::OFS_TVH) begin // [R2] [R23]
        case (tptr_reg) // [R7]
          rtc_pkg::PTR_0: now_reg.minute <= pwdata[7:0] & rtc_pkg::M_SEC;
          rtc_pkg::PTR_1: now_reg.wday <= pwdata[7:0] & rtc_pkg::M_WDAY;
          rtc_pkg::PTR_2: now_reg.month <= pwdata[7:0] & rtc_pkg::M_MONTH;
          default: ;
        endcase
      end
    end
  end

  // Only power-on reset touches configuration; no other reset input exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // [R8]
      en_reg <= 1'b0;
      unlock_reg <= 1'b0;
      oe_reg <= 1'b0;
      tptr_reg <= rtc_pkg::PTR_0;
    end else if (wr && paddr == rtc_pkg::OFS_CFG) begin
      if (unlock_reg)
        en_reg <= pwdata[rtc_pkg::CFG_EN]; // [R1]
      unlock_reg <= pwdata[rtc_pkg::CFG_UNLOCK];
      oe_reg <= pwdata[rtc_pkg::CFG_OE];
      tptr_reg <= pwdata[1:0];
    end else if (acc && paddr == rtc_pkg::OFS_TVH && tptr_reg != rtc_pkg::PTR_0)
      tptr_reg <= tptr_reg - 2'h1; // [R6]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_reg <= '0;
      sel_reg <= rtc_pkg::SEL_ALARM;
    end else if (wr && paddr == rtc_pkg::OFS_CAL)
      cal_reg <= pwdata[7:0];
    else if (wr && paddr == rtc_pkg::OFS_PAD)
      sel_reg <= pwdata[rtc_pkg::PAD_SEL_LO +: 2];
  end

  // Alarm field matches against the already advanced time
  assign sec_eq = now_reg.second == alm_reg.second;
  assign min_eq = now_reg.minute == alm_reg.minute;
  assign hour_eq = now_reg.hour == alm_reg.hour;
  assign wday_eq = now_reg.wday == alm_reg.wday;
  assign day_eq = now_reg.day == alm_reg.day;
  assign mon_eq = now_reg.month == alm_reg.month;

  always_comb begin
    case (alarm_interval_mask_reg) // [R14]
      rtc_pkg::AM_HALF: hit = sec_d_reg || half_d_reg;
      rtc_pkg::AM_SEC: hit = sec_d_reg;
      rtc_pkg::AM_10S: hit = sec_d_reg && now_reg.second[3:0] == alm_reg.second[3:0];
      rtc_pkg::AM_MIN: hit = sec_d_reg && sec_eq;
      rtc_pkg::AM_10M: hit = sec_d_reg && sec_eq && now_reg.minute[3:0] == alm_reg.minute[3:0];
      rtc_pkg::AM_HOUR: hit = sec_d_reg && sec_eq && min_eq;
      rtc_pkg::AM_DAY: hit = sec_d_reg && sec_eq && min_eq && hour_eq;
      rtc_pkg::AM_WEEK: hit = sec_d_reg && sec_eq && min_eq && hour_eq && wday_eq;
      rtc_pkg::AM_MONTH: hit = sec_d_reg && sec_eq && min_eq && hour_eq && day_eq;
      // Feb 29 only exists in leap years, so a yearly match there is four-yearly
      rtc_pkg::AM_YEAR: hit = sec_d_reg && sec_eq && min_eq && hour_eq && day_eq && mon_eq; // [R15]
      default: hit = 1'b0;
    endcase
  end

  assign evt = aen_reg && hit; // [R24]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_d_reg <= 1'b0;
      half_d_reg <= 1'b0;
      apulse_reg <= 1'b0;
    end else begin
      sec_d_reg <= sec_tick;
      half_d_reg <= half_tick;
      if (evt)
        apulse_reg <= 1'b1; // [R24]
      else if (sec_tick || half_tick)
        apulse_reg <= 1'b0;
    end
  end

  // A software write to the alarm controls beats a coinciding event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aen_reg <= 1'b0;
      chime_reg <= 1'b0;
      alarm_interval_mask_reg <= rtc_pkg::AM_HALF;
      aptr_reg <= rtc_pkg::PTR_0;
    end else if (wr && paddr == rtc_pkg::OFS_ACFG) begin
      aen_reg <= pwdata[rtc_pkg::ACF_EN];
      chime_reg <= pwdata[rtc_pkg::ACF_CHIME];
      alarm_interval_mask_reg <= pwdata[rtc_pkg::ACF_MASK_LO +: 4];
      aptr_reg <= pwdata[1:0];
    end else begin
      if (evt && rpt_reg == '0 && !chime_reg)
        aen_reg <= 1'b0; // [R11]
      if (acc && paddr == rtc_pkg::OFS_AVH) begin
        if (aptr_reg != rtc_pkg::PTR_0)
          aptr_reg <= aptr_reg - 2'h1; // [R16]
        else if (chime_reg)
          aptr_reg <= rtc_pkg::PTR_3; // [R13]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rpt_reg <= '0;
    else if (wr && paddr == rtc_pkg::OFS_RPT)
      rpt_reg <= pwdata[7:0]; // [R18]
    else if (evt && (rpt_reg != '0 || chime_reg))
      rpt_reg <= rpt_reg - 8'h1; // [R12] [R18]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      alm_reg <= rtc_pkg::TIME_RST;
    else if (wr && unlock_reg && paddr == rtc_pkg::OFS_AVL) begin
      case (aptr_reg) // [R17]
        rtc_pkg::PTR_0: alm_reg.second <= pwdata[7:0] & rtc_pkg::M_SEC;
        rtc_pkg::PTR_1: alm_reg.hour <= pwdata[7:0] & rtc_pkg::M_HOUR;
        rtc_pkg::PTR_2: alm_reg.day <= pwdata[7:0] & rtc_pkg::M_HOUR;
        default: ;
      endcase
    end else if (wr && unlock_reg && paddr == rtc_pkg::OFS_AVH) begin
      case (aptr_reg) // [R17]
        rtc_pkg::PTR_0: alm_reg.minute <= pwdata[7:0] & rtc_pkg::M_SEC;
        rtc_pkg::PTR_1: alm_reg.wday <= pwdata[7:0] & rtc_pkg::M_WDAY;
        rtc_pkg::PTR_2: alm_reg.month <= pwdata[7:0] & rtc_pkg::M_MONTH;
        default: ;
      endcase
    end
  end

  // Read byte decode; pointer-selected windows read zero at unimplemented codes
  always_comb begin
    rbyte = '0;
    mapped = 1'b1;
    case (paddr)
      rtc_pkg::OFS_CFG:
        rbyte = {en_reg, 1'b0, unlock_reg, sync_reg, phase_reg, oe_reg, tptr_reg}; // [R3] [R4]
      rtc_pkg::OFS_CAL: rbyte = cal_reg;
      rtc_pkg::OFS_PAD: rbyte = {5'h0, sel_reg, 1'b0};
      rtc_pkg::OFS_ACFG: rbyte = {aen_reg, chime_reg, alarm_interval_mask_reg, aptr_reg};
      rtc_pkg::OFS_RPT: rbyte = rpt_reg;
      rtc_pkg::OFS_TVL:
        case (tptr_reg) // [R7]
          rtc_pkg::PTR_0: rbyte = now_reg.second;
          rtc_pkg::PTR_1: rbyte = now_reg.hour;
          rtc_pkg::PTR_2: rbyte = now_reg.day;
          default: rbyte = now_reg.year;
        endcase
      rtc_pkg::OFS_TVH:
        case (tptr_reg) // [R7]
          rtc_pkg::PTR_0: rbyte = now_reg.minute;
          rtc_pkg::PTR_1: rbyte = now_reg.wday;
          rtc_pkg::PTR_2: rbyte = now_reg.month;
          default: rbyte = '0;
        endcase
      rtc_pkg::OFS_AVL:
        case (aptr_reg) // [R17]
          rtc_pkg::PTR_0: rbyte = alm_reg.second;
          rtc_pkg::PTR_1: rbyte = alm_reg.hour;
          rtc_pkg::PTR_2: rbyte = alm_reg.day;
          default: rbyte = '0;
        endcase
      rtc_pkg::OFS_AVH:
        case (aptr_reg) // [R17]
          rtc_pkg::PTR_0: rbyte = alm_reg.minute;
          rtc_pkg::PTR_1: rbyte = alm_reg.wday;
          rtc_pkg::PTR_2: rbyte = alm_reg.month;
          default: rbyte = '0;
        endcase
      default: mapped = 1'b0;
    endcase
  end

  // Ready in the first access cycle with no wait state; every APB output registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= {24'h0, rbyte};
      pready_reg <= 1'b1;
      pslverr_reg <= !mapped;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_oe_n_reg <= !oe_reg; // [R5]
      if (!oe_reg)
        pin_reg <= 1'b0; // [R5]
      else
        case (sel_reg) // [R10]
          rtc_pkg::SEL_ALARM: pin_reg <= apulse_reg;
          rtc_pkg::SEL_SEC: pin_reg <= !phase_reg;
          rtc_pkg::SEL_SRC: pin_reg <= osc_d_reg;
          default: pin_reg <= 1'b0;
        endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rtc_pin_o = pin_reg;
  assign rtc_pin_oe_n = pin_oe_n_reg;
endmodule // rtc_calendar_alarm_control
`default_nettype wire

// ===== hw/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
  // BCD fields, one byte each
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } time_s;
  localparam int SRC_HZ = 32768;
  localparam int HALF_TICKS = SRC_HZ / 2;
  localparam int SYNC_TICKS = 32;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CAL = 8'h04;
  localparam logic [7:0] OFS_PAD = 8'h08;
  localparam logic [7:0] OFS_ACFG = 8'h0c;
  localparam logic [7:0] OFS_RPT = 8'h10;
  localparam logic [7:0] OFS_TVL = 8'h14;
  localparam logic [7:0] OFS_TVH = 8'h18;
  localparam logic [7:0] OFS_AVL = 8'h1c;
  localparam logic [7:0] OFS_AVH = 8'h20;
  localparam int CFG_EN = 7;
  localparam int CFG_UNLOCK = 5;
  localparam int CFG_OE = 2;
  localparam int ACF_EN = 7;
  localparam int ACF_CHIME = 6;
  localparam int ACF_MASK_LO = 2;
  localparam int PAD_SEL_LO = 1;
  localparam logic [3:0] AM_HALF = 4'h0;
  localparam logic [3:0] AM_SEC = 4'h1;
  localparam logic [3:0] AM_10S = 4'h2;
  localparam logic [3:0] AM_MIN = 4'h3;
  localparam logic [3:0] AM_10M = 4'h4;
  localparam logic [3:0] AM_HOUR = 4'h5;
  localparam logic [3:0] AM_DAY = 4'h6;
  localparam logic [3:0] AM_WEEK = 4'h7;
  localparam logic [3:0] AM_MONTH = 4'h8;
  localparam logic [3:0] AM_YEAR = 4'h9;
  localparam logic [1:0] SEL_ALARM = 2'h0;
  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_SRC = 2'h2;
  localparam logic [1:0] PTR_0 = 2'h0;
  localparam logic [1:0] PTR_1 = 2'h1;
  localparam logic [1:0] PTR_2 = 2'h2;
  localparam logic [1:0] PTR_3 = 2'h3;
  localparam logic [7:0] MAX_SEC = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [7:0] MAX_WDAY = 8'h06;
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam logic [7:0] M_SEC = 8'h7f;
  localparam logic [7:0] M_HOUR = 8'h3f;
  localparam logic [7:0] M_WDAY = 8'h07;
  localparam logic [7:0] M_MONTH = 8'h1f;
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [7:0] D28 = 8'h28;
  localparam logic [7:0] D29 = 8'h29;
  localparam logic [7:0] D30 = 8'h30;
  localparam logic [7:0] D31 = 8'h31;
  localparam time_s TIME_RST = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
endpackage
`default_nettype wire

// ===== sim/rtc_calendar_alarm_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_control_asserts (
  input wire logic pclk, // Clock
  input wire logic presetn, // Power-on reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Byte address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic osc_in, // Source level
  input wire logic rtc_pin_o, // Pin level
  input wire logic rtc_pin_oe_n // Pin enable, active low
);
  default clocking
    @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [1:0] sel_q;
  logic wr_acc;
  logic oe_wr;
  logic unmapped;
  assign wr_acc = psel && penable && pready && pwrite;
  assign oe_wr = pwdata[rtc_pkg::CFG_OE];
  assign unmapped = paddr > rtc_pkg::OFS_AVH || paddr[1:0] != 2'h0;
  // Shadow of the output select, so the reserved code can be watched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 2'h0;
    end else if (wr_acc && paddr == rtc_pkg::OFS_PAD) begin
      sel_q <= pwdata[2:1];
    end
  end
  ready_after_setup_a: assert property (psel && !penable |=> pready && psel && penable)
    else $error("no ready in access cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_decode_a: assert property (pready |-> pslverr == unmapped)
    else $error("error flag wrong for address");
  read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  oe_follow_a: assert property (wr_acc && paddr == rtc_pkg::OFS_CFG |=> ##1
    rtc_pin_oe_n == !$past(oe_wr, 2)) else $error("pin enable not following write");
  pin_quiet_a: assert property (rtc_pin_oe_n |-> !rtc_pin_o)
    else $error("pin active while disabled");
  reserved_sel_a: assert property (sel_q == 2'h3 && $past(sel_q) == 2'h3 |-> !rtc_pin_o)
    else $error("reserved select drives pin");
endmodule // rtc_calendar_alarm_control_asserts
bind rtc_calendar_alarm_control rtc_calendar_alarm_control_asserts i_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_in,
  .rtc_pin_o, .rtc_pin_oe_n);
`default_nettype wire

// ===== sim/rtc_calendar_alarm_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", n, e, g); \
    end \
  end
module rtc_calendar_alarm_control_bench;
  // Short half second keeps a simulated minute near 4000 cycles
  localparam int HT = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc_in = 1'b0;
  logic [1:0] osc_div = 2'h0;
  logic rtc_pin_o;
  logic rtc_pin_oe_n;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int checks_done = 0;
  rtc_calendar_alarm_control #(.HALF_TICKS(HT), .SYNC_TICKS(2)) i_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_in,
    .rtc_pin_o, .rtc_pin_oe_n);
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Source tick every 4 cycles, so one second is 64 cycles
  always @(posedge pclk) begin
    osc_div <= osc_div + 2'h1;
    osc_in <= osc_div[1];
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, {24'h0, e}, rd)
    `CHK("error flag", 1'b0, er)
  endtask
  task automatic count_rise(input int cyc, input int stop, output int cnt);
    logic prev;
    cnt = 0;
    prev = rtc_pin_o;
    for (int i = 0; i < cyc && cnt < stop; i++) begin
      @(posedge pclk);
      if (rtc_pin_o === 1'b1 && prev !== 1'b1) begin
        cnt++;
      end
      prev = rtc_pin_o;
    end
  endtask
  task automatic poll(input int b, input string n);
    int k;
    k = 0;
    do begin
      apb(1'b0, rtc_pkg::OFS_CFG, 32'h0);
      k++;
    end while (rd[b] !== 1'b1 && k < 60);
    `CHK(n, 1'b1, rd[b])
  endtask
  // High window sits one word above the low window, for time and alarm alike
  task automatic read_back(input logic [7:0] a, input logic [15:0] t[4]);
    for (int i = 0; i < 4; i++) begin
      rdc(a, t[i][15:8], "window low");
      rdc(a + 8'h04, t[i][7:0], "window high");
    end
  endtask
  task automatic load(input logic [7:0] a, input logic [15:0] t[4]);
    for (int i = 0; i < 4; i++) begin
      wr(a, t[i][15:8]);
      wr(a + 8'h04, t[i][7:0]);
    end
  endtask
  task automatic t_reset();
    `CHK("pin enable", 1'b1, rtc_pin_oe_n)
    for (int a = 0; a <= 24; a += 4) begin
      rdc(a[7:0], 8'h00, "reset value");
    end
    apb(1'b0, 8'h24, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    $display("reset test done");
  endtask
  task automatic t_window();
    logic [15:0] tv[4] = '{16'h9600, 16'h2802, 16'h2306, 16'h5859};
    logic [15:0] nx[4] = '{16'h9600, 16'h2902, 16'h0000, 16'h0000};
    wr(rtc_pkg::OFS_CFG, 8'h80);
    rdc(rtc_pkg::OFS_CFG, 8'h00, "locked enable");
    wr(rtc_pkg::OFS_TVL, 8'h30);
    rdc(rtc_pkg::OFS_TVL, 8'h00, "locked write");
    wr(rtc_pkg::OFS_CFG, 8'h23);
    load(rtc_pkg::OFS_TVL, tv);
    wr(rtc_pkg::OFS_TVH, 8'h59);
    rdc(rtc_pkg::OFS_CFG, 8'h20, "pointer stop");
    repeat (70) @(posedge pclk);
    wr(rtc_pkg::OFS_CFG, 8'h23);
    read_back(rtc_pkg::OFS_TVL, tv);
    wr(rtc_pkg::OFS_CFG, 8'ha3);
    repeat (140) @(posedge pclk);
    read_back(rtc_pkg::OFS_TVL, nx);
    $display("window test done");
  endtask
  task automatic t_status();
    poll(4, "ripple status");
    poll(3, "half phase");
    wr(rtc_pkg::OFS_CFG, 8'ha0);
    wr(rtc_pkg::OFS_TVL, 8'h10);
    rdc(rtc_pkg::OFS_CFG, 8'ha0, "half cleared");
    rdc(rtc_pkg::OFS_TVL, 8'h10, "seconds");
    $display("status test done");
  endtask
  task automatic t_pin();
    int t;
    logic [7:0] pads[4] = '{8'h04, 8'h02, 8'h06, 8'h00};
    wr(rtc_pkg::OFS_PAD, 8'h04);
    count_rise(40, 99, t);
    `CHK("pin while disabled", 0, t)
    wr(rtc_pkg::OFS_CFG, 8'ha4);
    repeat (2) @(posedge pclk);
    `CHK("pin enable", 1'b0, rtc_pin_oe_n)
    for (int i = 0; i < 4; i++) begin
      wr(rtc_pkg::OFS_PAD, pads[i]);
      count_rise(70, 99, t);
      `CHK("pin activity", i < 2, t > 0)
    end
    $display("pin test done");
  endtask
  task automatic t_alarm(input logic [7:0] r, input int s, input int e);
    int t;
    wr(rtc_pkg::OFS_RPT, r);
    wr(rtc_pkg::OFS_ACFG, 8'h84);
    count_rise(s * 8 * HT, 999, t);
    `CHK("alarm events", e, t)
    rdc(rtc_pkg::OFS_ACFG, 8'h04, "alarm enable");
    rdc(rtc_pkg::OFS_RPT, 8'h00, "repeat left");
    $display("alarm test done");
  endtask
  task automatic t_chime();
    int t;
    wr(rtc_pkg::OFS_RPT, 8'h00);
    wr(rtc_pkg::OFS_ACFG, 8'hc6);
    count_rise(80, 1, t);
    `CHK("chime event", 1, t)
    rdc(rtc_pkg::OFS_RPT, 8'hff, "chime wrap");
    rdc(rtc_pkg::OFS_ACFG, 8'hc6, "chime keeps enable");
    repeat (3) apb(1'b0, rtc_pkg::OFS_AVH, 32'h0);
    rdc(rtc_pkg::OFS_ACFG, 8'hc7, "pointer wrap");
    wr(rtc_pkg::OFS_ACFG, 8'h02);
    repeat (3) apb(1'b0, rtc_pkg::OFS_AVH, 32'h0);
    rdc(rtc_pkg::OFS_ACFG, 8'h00, "pointer stop");
    $display("chime test done");
  endtask
  // Feb 29 yearly alarm: silent in a common year, fires in a leap year
  task automatic t_year();
    int t;
    logic [15:0] al[4] = '{16'h0000, 16'h2902, 16'h0000, 16'h0000};
    logic [15:0] tm[4] = '{16'h9500, 16'h2802, 16'h2300, 16'h5859};
    wr(rtc_pkg::OFS_ACFG, 8'h03);
    load(rtc_pkg::OFS_AVL, al);
    wr(rtc_pkg::OFS_ACFG, 8'h03);
    read_back(rtc_pkg::OFS_AVL, al);
    for (int y = 0; y < 2; y++) begin
      tm[0][15:8] = y ? 8'h96 : 8'h95;
      wr(rtc_pkg::OFS_CFG, 8'h23);
      load(rtc_pkg::OFS_TVL, tm);
      wr(rtc_pkg::OFS_ACFG, 8'ha4);
      wr(rtc_pkg::OFS_CFG, 8'ha4);
      count_rise(200, 9, t);
      `CHK("leap year alarm", y, t)
    end
    $display("year alarm test done");
  endtask
  // Seconds clock on the pin; the first second of a minute is trimmed by the calibration
  task automatic t_cal(input logic [7:0] c, input int e);
    int t;
    wr(rtc_pkg::OFS_PAD, 8'h02);
    wr(rtc_pkg::OFS_CAL, c);
    rdc(rtc_pkg::OFS_CAL, c, "calibration");
    wr(rtc_pkg::OFS_TVL, 8'h59);
    count_rise(8, 1, t);
    count_rise(70, 1, t);
    `CHK("minute start", 1, t)
    count_rise(e - 2, 1, t);
    `CHK("early second", 0, t)
    count_rise(4, 1, t);
    `CHK("calibrated second", 1, t)
    $display("calibration test done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_window();
    t_status();
    t_pin();
    t_alarm(8'h02, 5, 3);
    t_alarm(8'h00, 3, 1);
    t_alarm(8'hff, 260, 256);
    t_chime();
    t_year();
    // Four cycles per source tick, calibration moves four ticks per unit
    t_cal(8'h01, 4 * (2 * HT - 4));
    t_cal(8'hff, 4 * (2 * HT + 4));
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    summarize();
  end
endmodule // rtc_calendar_alarm_control_bench
`default_nettype wire
